// File: logic/tpadc_backend.sv
// Digital back end of a three-channel pipelined sampling converter
`timescale 1ns/10ps
`default_nettype none
module tpadc_backend #(
  parameter int NUM_CH = tpadc_pkg::NUM_CH,
  parameter int RES_BITS = tpadc_pkg::RES_BITS,
  parameter int FIFO_DEPTH = tpadc_pkg::FIFO_DEPTH
) (
  input wire logic CORE_CLK, // 200 MHz core clock
  input wire logic RST, // Synchronous reset, high
  input wire logic CE, // Clock enable, freezes state when low
  input wire logic SAMPLE_CLK_IN, // Master sample clock pin
  input wire logic [NUM_CH*(RES_BITS-1)*2-1:0] STAGE_WORDS, // Subconverter words
  input wire logic OUTPUT_FORMAT_SELECT, // Low offset binary, high two's comp
  output logic PHASE_SAMPLE, // Sampling phase
  output logic PHASE_HOLD, // Hold or amplify phase
  output logic [RES_BITS-2:0] STAGE_CLK, // Per-stage phase, alternating
  output logic [NUM_CH*RES_BITS-1:0] DATA_OUT, // Output bus, channel 0 low
  output logic DATA_VALID, // Output word is past power-up window
  output logic DATA_STROBE // One-cycle pulse when DATA_OUT changes
);
  localparam int NSTG = RES_BITS - 1;
  localparam int CHW = NSTG * tpadc_pkg::STAGE_WORD_BITS;
  localparam int PINW = NUM_CH * CHW;
  localparam int LAST_LAT = tpadc_pkg::stage_lat(NSTG - 1);
  localparam int DW = NUM_CH * RES_BITS;
  localparam int PIPE_LAT = LAST_LAT + 1 + tpadc_pkg::OUTPUT_LATCH_CYCLES;

  // ========================================================================
  // Elaboration checks
  if (RES_BITS < 3) begin : g_bad_res
    $error("Resolution too small for a pipeline");
  end
  if (NUM_CH < 1) begin : g_bad_ch
    $error("At least one channel needed");
  end
  if (RES_BITS == tpadc_pkg::RES_BITS
      && PIPE_LAT != tpadc_pkg::OUTPUT_LATENCY_CYCLES) begin : g_bad_lat
    $error("Pipeline depth does not give the output latency");
  end

  // Weighted sum of one channel's aligned words, saturated at full scale
  function automatic logic [RES_BITS-1:0] correct_f(input logic [CHW-1:0] w);
    logic [RES_BITS:0] acc;
    acc = '0;
    for (int i = 0; i < NSTG; i++) begin
      acc = acc + ((RES_BITS+1)'(w[2*i +: 2]) << (NSTG - 1 - i));
    end
    return acc[RES_BITS] ? '1 : acc[RES_BITS-1:0];
  endfunction : correct_f

  // ========================================================================
  // Pin synchronisers
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_d_q;
  logic [PINW-1:0] words_s1_q;
  logic [PINW-1:0] words_s2_q;
  logic fmt_s1_q;
  logic fmt_s2_q;

  // Two flops on every pin but RST and CE before use
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      fmt_s1_q <= tpadc_pkg::FMT_OFFSET_BINARY;
      fmt_s2_q <= tpadc_pkg::FMT_OFFSET_BINARY;
    end else if (CE) begin
      sclk_s1_q <= SAMPLE_CLK_IN;
      sclk_s2_q <= sclk_s1_q;
      fmt_s1_q <= OUTPUT_FORMAT_SELECT;
      fmt_s2_q <= fmt_s1_q;
    end
  end

  // Stage words follow the pins; only the sample event consumes them
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      words_s1_q <= '0;
      words_s2_q <= '0;
    end else if (CE) begin
      words_s1_q <= STAGE_WORDS;
      words_s2_q <= words_s1_q;
    end
  end

  // ========================================================================
  // Two-phase clock
  logic phi1_q;
  logic phi2_q;
  logic evt;
  logic stall;

  // Each phase needs both taps to agree, so a dead cycle separates them
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sclk_d_q <= 1'b0;
      phi1_q <= 1'b0;
      phi2_q <= 1'b0;
    end else if (CE) begin
      sclk_d_q <= sclk_s2_q;
      phi1_q <= sclk_s2_q && sclk_d_q;
      phi2_q <= !sclk_s2_q && !sclk_d_q;
    end
  end

  // Sample is taken where the sampling phase falls
  assign evt = phi1_q && !(sclk_s2_q && sclk_d_q);

  assign PHASE_SAMPLE = phi1_q;
  assign PHASE_HOLD = phi2_q;

  // Alternate stages share a phase, neighbours are half a period apart
  for (genvar k = 0; k < NSTG; k++) begin : g_stclk
    assign STAGE_CLK[k] = (k % 2 == 0) ? phi1_q : phi2_q;
  end

  // ========================================================================
  // Delay line: stage i is held until the last stage catches up
  logic [PINW-1:0] aligned;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    for (genvar i = 0; i < NSTG; i++) begin : g_stg
      localparam int D = LAST_LAT - tpadc_pkg::stage_lat(i);
      localparam int B = c * CHW + 2 * i;
      if (D == 0) begin : g_direct
        // Last-stage flash word is used as it arrives
        assign aligned[B +: 2] = words_s2_q[B +: 2];
      end else begin : g_delay
        logic [1:0] dly_q [D];
        // Shift on each sample event, held while the FIFO is full
        always_ff @(posedge CORE_CLK) begin
          if (RST) begin
            for (int j = 0; j < D; j++) dly_q[j] <= 2'h0;
          end else if (CE && evt && !stall) begin
            dly_q[0] <= words_s2_q[B +: 2];
            for (int j = 1; j < D; j++) dly_q[j] <= dly_q[j-1];
          end
        end
        assign aligned[B +: 2] = dly_q[D-1];
      end
    end
  end

  // ========================================================================
  // Error correction into the first latch (the FIFO)
  tpadc_fifo_if #(.WIDTH(DW)) fq ();
  logic [DW-1:0] corrected;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_corr
    assign corrected[c*RES_BITS +: RES_BITS] = correct_f(aligned[c*CHW +: CHW]);
  end

  assign fq.push_valid = evt;
  assign fq.push_data = corrected;
  // A full FIFO freezes the delay line rather than dropping a sample
  assign stall = !fq.push_ready;
  // Second latch drains one word on every sample event
  assign fq.pop_ready = evt;

  tpadc_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CE),
    .bus(fq)
  );

  // ========================================================================
  // Second latch and output format
  logic [DW-1:0] out_q;
  logic strobe_q;
  logic [tpadc_pkg::STARTUP_CNT_BITS-1:0] start_q;
  logic valid_q;

  // Output register, MSB flipped per channel for two's complement
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      out_q <= '0;
    end else if (CE && evt && fq.pop_valid) begin
      for (int c = 0; c < NUM_CH; c++) begin
        out_q[c*RES_BITS +: RES_BITS] <= fq.pop_data[c*RES_BITS +: RES_BITS]
          ^ {(fmt_s2_q == tpadc_pkg::FMT_TWOS_COMP), {(RES_BITS-1){1'b0}}};
      end
    end
  end

  // Strobe marks each new word, one per sample cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      strobe_q <= 1'b0;
    end else if (CE) begin
      strobe_q <= evt && fq.pop_valid;
    end
  end

  // Power-up window counted in sample cycles; capture logic must wait
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      start_q <= tpadc_pkg::STARTUP_CNT_RST;
      valid_q <= 1'b0;
    end else if (CE && evt) begin
      if (start_q != 5'(tpadc_pkg::POWERUP_INVALID_CYCLES)) begin
        start_q <= start_q + 1'b1;
      end else begin
        valid_q <= 1'b1;
      end
    end
  end

  assign DATA_OUT = out_q;
  assign DATA_STROBE = strobe_q;
  assign DATA_VALID = valid_q;

  // ========================================================================
  // Checking helpers
  logic [1:0] hist_q [LAST_LAT];
  logic [DW-1:0] last_pop_q;
  logic last_fmt_q;

  // Stage-0 word of channel 0 remembered per event
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int j = 0; j < LAST_LAT; j++) hist_q[j] <= 2'h0;
      last_pop_q <= '0;
      last_fmt_q <= 1'b0;
    end else if (CE && evt) begin
      hist_q[0] <= words_s2_q[1:0];
      for (int j = 1; j < LAST_LAT; j++) hist_q[j] <= hist_q[j-1];
      last_pop_q <= fq.pop_data;
      last_fmt_q <= fmt_s2_q;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_phase_gap;
    !(phi1_q && phi2_q) && !(phi1_q && $past(phi2_q)) && !(phi2_q && $past(phi1_q));
  endproperty
  a_phase_gap: assert property (p_phase_gap) else $error("Phases overlap");

  property p_sample_fall;
    (CE && evt) |=> !phi1_q;
  endproperty
  a_sample_fall: assert property (p_sample_fall) else $error("Sample not at fall");

  property p_stage_alt;
    (NSTG < 2) || (STAGE_CLK[0] == phi1_q && STAGE_CLK[1] == phi2_q);
  endproperty
  a_stage_alt: assert property (p_stage_alt) else $error("Stage clocks not alternating");

  property p_align;
    (evt && !stall && start_q > 5'(LAST_LAT)) |-> aligned[1:0] == hist_q[LAST_LAT-1];
  endproperty
  a_align: assert property (p_align) else $error("Delay line misaligned");

  property p_zero_upper;
    (evt && aligned[CHW-3:0] == '0) |-> corrected[RES_BITS-1:0] == RES_BITS'(aligned[CHW-1 -: 2]);
  endproperty
  a_zero_upper: assert property (p_zero_upper) else $error("Correction wrong");

  property p_second_latch;
    DATA_STROBE |-> (DATA_OUT[RES_BITS-2:0] == last_pop_q[RES_BITS-2:0]);
  endproperty
  a_second_latch: assert property (p_second_latch) else $error("Latch data wrong");

  property p_format;
    DATA_STROBE |-> DATA_OUT[RES_BITS-1] == (last_pop_q[RES_BITS-1] ^ last_fmt_q);
  endproperty
  a_format: assert property (p_format) else $error("Format bit wrong");

  property p_strobe;
    (CE && evt && fq.pop_valid) |=> DATA_STROBE ##1 !DATA_STROBE;
  endproperty
  a_strobe: assert property (p_strobe) else $error("Strobe not one cycle");

  property p_startup;
    DATA_VALID |-> start_q == 5'(tpadc_pkg::POWERUP_INVALID_CYCLES);
  endproperty
  a_startup: assert property (p_startup) else $error("Valid before window");

  property p_no_overflow;
    (CE && evt) |-> fq.push_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("FIFO filled");

  property p_pop_each;
    (CE && evt && start_q != tpadc_pkg::STARTUP_CNT_RST) |-> fq.pop_valid;
  endproperty
  a_pop_each: assert property (p_pop_each) else $error("Event without a word");

  property p_valid_hold;
    DATA_VALID |=> DATA_VALID;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("Valid dropped");

  // Freeze and steady streaming are the cases most likely to break alignment
  c_freeze: cover property (!CE && phi1_q);
  c_stream: cover property (DATA_STROBE ##[1:40] DATA_STROBE);
  c_valid: cover property ($rose(DATA_VALID));
  c_twos: cover property (DATA_STROBE && last_fmt_q);
  c_offset: cover property (DATA_STROBE && !last_fmt_q && DATA_VALID);
endmodule : tpadc_backend
`default_nettype wire

// File: logic/tpadc_fifo.sv
// First latch stage of the output path: a small show-ahead FIFO
`timescale 1ns/10ps
`default_nettype none
module tpadc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, high
  input wire logic ce, // Clock enable
  tpadc_fifo_if.fifo bus // Push and pop sides
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Pointer wrap logic only works for power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end

  // Full when pointers differ only in the wrap bit
  assign bus.push_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign bus.pop_valid = (wr_q != rd_q);
  assign bus.pop_data = mem_q[rd_q[AW-1:0]];
  assign push = bus.push_valid && bus.push_ready;
  assign pop = bus.pop_valid && bus.pop_ready;

  // Storage; no reset needed, valid is tracked by pointers
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_q[AW-1:0]] <= bus.push_data;
    end
  end

  // Write pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
    end else if (ce && push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
    end else if (ce && pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule : tpadc_fifo
`default_nettype wire

// File: logic/tpadc_fifo_if.sv
// Carrier between the back end and its result FIFO
`timescale 1ns/10ps
`default_nettype none
interface tpadc_fifo_if #(
  parameter int WIDTH = 24
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport fill (output push_valid, input push_ready, output push_data,
                input pop_valid, output pop_ready, input pop_data);
  modport fifo (input push_valid, output push_ready, input push_data,
                output pop_valid, input pop_ready, output pop_data);
endinterface : tpadc_fifo_if
`default_nettype wire

// File: logic/tpadc_pkg.sv
// Constants and helpers shared by the converter digital back end
// ==========================================================================
package tpadc_pkg;
  // ========================================================================
  // Structure
  localparam int NUM_CH = 3;
  localparam int RES_BITS = 8;
  localparam int STAGE_WORD_BITS = 2;
  localparam int SYNC_STAGES = 2;
  localparam int FIFO_DEPTH = 8;
  // ========================================================================
  // Timing, counted in sample-clock cycles
  localparam int OUTPUT_LATENCY_CYCLES = 5;
  localparam int POWERUP_INVALID_CYCLES = 20;
  localparam int OUTPUT_LATCH_CYCLES = 1;
  localparam int STARTUP_CNT_BITS = 5;
  localparam logic [4:0] STARTUP_CNT_RST = 5'h00;
  // ========================================================================
  // Format select levels
  localparam logic FMT_OFFSET_BINARY = 1'b0;
  localparam logic FMT_TWOS_COMP = 1'b1;

  // Stage i decides half a sample period after stage i-1
  function automatic int stage_lat(input int i);
    return i / 2;
  endfunction : stage_lat
endpackage : tpadc_pkg

// File: tb/test_triple_pipeline_adc_digital_backend.sv
// Self-checking bench for the converter digital back end
`timescale 1ns/10ps
`default_nettype none
module test_triple_pipeline_adc_digital_backend;
  localparam int NC = tpadc_pkg::NUM_CH;
  localparam int RB = tpadc_pkg::RES_BITS;
  localparam int W = NC * RB;
  localparam int SW = NC * (RB - 1) * 2;
  // Two streams of under 80 events at 16 cycles each, with a wide margin
  localparam int TIMEOUT_NS = 4 * 80 * 16 * 5;
  logic core_clk, rst, ce, sample_clk, fmt;
  logic [SW-1:0] stage_words;
  logic ps, ph, valid, strobe;
  logic [RB-2:0] stage_clk;
  logic [W-1:0] data_out;
  logic [7:0] n_ok, n_drop;
  int fails, check_count;
  logic ps_prev;
  logic [W-1:0] out_prev;

  // ==========================================================================
  // Clock, design and capture model
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  tpadc_backend i_dut (.CORE_CLK(core_clk), .RST(rst), .CE(ce), .SAMPLE_CLK_IN(sample_clk),
    .STAGE_WORDS(stage_words), .OUTPUT_FORMAT_SELECT(fmt), .PHASE_SAMPLE(ps),
    .PHASE_HOLD(ph), .STAGE_CLK(stage_clk), .DATA_OUT(data_out), .DATA_VALID(valid),
    .DATA_STROBE(strobe));
  tpadc_capture #(.W(W)) i_cap (.clk(core_clk), .rst(rst), .ce(ce), .data(data_out),
    .valid(valid), .strobe(strobe), .n_ok(n_ok), .n_drop(n_drop));

  // ==========================================================================
  // Checking and closing
  task automatic chk(input string name, input logic [W-1:0] seen, input logic [W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  // Decision of stage i for sample n on channel c; stage 0 saturates now and then
  function automatic int dec(input int n, input int c, input int i);
    if (i == RB - 2) return (n + c) % 4;
    if (i == 0 && n % 9 == 4) return 3;
    return (n * 5 + c + i) % 3;
  endfunction : dec

  function automatic logic [W-1:0] exp_word(input int n, input logic f);
    logic [W-1:0] w;
    int s;
    for (int c = 0; c < NC; c++) begin
      s = 0;
      for (int i = 0; i < RB - 1; i++) s += dec(n, c, i) << (RB - 2 - i);
      if (s > 2 ** RB - 1) s = 2 ** RB - 1;
      w[c*RB +: RB] = s[RB-1:0];
      if (f) w[c*RB+RB-1] = ~w[c*RB+RB-1];
    end
    return w;
  endfunction : exp_word

  // ==========================================================================
  // Continuous watch on phases, strobe timing and output holding
  // Sampled on the falling edge, where registered outputs have settled
  always @(negedge core_clk) begin
    if (!rst) begin
      chk("phase overlap", W'(ps & ph), '0);
      chk("stage clocks", W'(stage_clk), W'({ps, ph, ps, ph, ps, ph, ps}));
      if (strobe) chk("strobe after sample edge", W'({ps_prev, ps}), W'(2'b10));
      if (!strobe) chk("output held", data_out, out_prev);
    end
    ps_prev = ps;
    out_prev = data_out;
  end

  // ==========================================================================
  // Stream driver: stage words for event e carry sample e-1-i/2 on stage i
  task automatic run_stream(input logic f, input int events);
    logic [SW-1:0] sw;
    int s;
    fmt = f;
    for (int e = 0; e < events; e++) begin
      sw = '0;
      for (int c = 0; c < NC; c++) begin
        for (int i = 0; i < RB - 1; i++) begin
          s = e - 1 - i / 2;
          if (s >= 0) sw[c*(RB-1)*2+2*i +: 2] = 2'(dec(s, c, i));
        end
      end
      stage_words = sw;
      sample_clk = 1'b1;
      // Freeze mid-stream, away from any strobe; results must not shift
      if (e == 23) begin
        ce = 1'b0;
        repeat (3) tick();
        ce = 1'b1;
      end
      repeat (8) tick();
      sample_clk = 1'b0;
      repeat (8) tick();
    end
    // The first event after reset has nothing to hand on yet
    chk("word count", W'(n_ok) + W'(n_drop), W'(events - 1));
    chk("dropped in window", W'(n_drop >= 19 && n_drop <= 20), W'(1));
    for (int j = 0; j < n_ok; j++) begin
      // Strobe k comes from event k+1 and shows the sample five events back
      s = n_drop + j + 1 - tpadc_pkg::OUTPUT_LATENCY_CYCLES;
      chk("word", i_cap.word_q[j], exp_word(s, f));
    end
  endtask : run_stream

  // ==========================================================================
  // Scenarios
  task automatic t_offset_binary();
    run_stream(1'b0, 40);
  endtask : t_offset_binary

  // Second reset mid-run, then the first 34 events of the same stream in two's complement
  task automatic t_twos_complement();
    rst = 1'b1;
    repeat (6) tick();
    rst = 1'b0;
    tick();
    chk("out after reset", data_out, '0);
    chk("valid after reset", W'(valid), '0);
    run_stream(1'b1, 34);
  endtask : t_twos_complement

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    fails = 0;
    check_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    sample_clk = 1'b0;
    fmt = 1'b0;
    stage_words = '0;
    repeat (6) tick();
    rst = 1'b0;
    repeat (5) tick();
    t_offset_binary();
    t_twos_complement();
    end_sim();
  end

  initial begin
    #(TIMEOUT_NS);
    fails++;
    end_sim();
  end
endmodule : test_triple_pipeline_adc_digital_backend
`default_nettype wire

// File: tb/tpadc_capture.sv
// Model of the external logic that captures converted words
`timescale 1ns/10ps
`default_nettype none
module tpadc_capture #(
  parameter int W = 24
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, high
  input wire logic ce, // Clock enable of the converter side
  input wire logic [W-1:0] data, // Output bus
  input wire logic valid, // Word past power-up window
  input wire logic strobe, // New word pulse
  output logic [7:0] n_ok, // Words kept
  output logic [7:0] n_drop // Words thrown away
);
  logic [W-1:0] word_q [0:255];
  // ==========================================================================
  // Capture
  // Early words may be garbage, so they are counted but never kept
  always_ff @(posedge clk) begin
    if (rst) begin
      n_ok <= 8'h00;
      n_drop <= 8'h00;
    end else if (ce && strobe && valid) begin
      word_q[n_ok] <= data;
      n_ok <= n_ok + 8'h01;
    end else if (ce && strobe) begin
      n_drop <= n_drop + 8'h01;
    end
  end
endmodule : tpadc_capture
`default_nettype wire
